// file: logic/standby_pkg.sv
package standby_pkg;
   // halt operand decode
   localparam logic [2:0] op_stop_all_a = 3'h0;
   localparam logic [2:0] op_stop_all_b = 3'h3;
   localparam logic [2:0] op_stop_k0 = 3'h6;
   localparam logic [2:0] op_halt_timer = 3'h5;
   localparam int op_sense_bit = 3;
   // reset values of the architected state
   localparam logic [9:0] pc_reset = 10'h000;
   localparam logic stack_pointer_reset = 1'b0;
   localparam logic [9:0] rom_data_pointer_reset = 10'h000;
   localparam logic [9:0] timer_reset = 10'h000;
   localparam logic [7:0] port_register_low_reset = 8'hFF;
   localparam logic [3:0] port_register_high_low_nibble = 4'hF;
   localparam logic [7:0] control_register_zero_reset = 8'h03;
   localparam logic [7:0] control_register_one_reset = 8'h26;
   // bit positions in control register one
   localparam int ctl1_sense0_in_bit = 0;
   localparam int ctl1_key_io_out_bit = 1;
   localparam int ctl1_sense1_led_bit = 2;
   // waits after reset release and after stop wake, in system clocks
   localparam int reset_wait_min = 246;
   localparam int reset_wait_max = 694;
   localparam int osc_growth_default = 16;
   localparam int osc_wait_default = 246;
   // the wait counter width covers the longest wait
   localparam int wait_w = 10;
   typedef enum logic [2:0] {
      st_reset, st_grow, st_wait, st_run, st_clear_timer, st_stop, st_halt
   } seq_state_t;
endpackage

// file: logic/wake_if.sv
interface wake_if;
   logic [3:0] operand;
   logic [3:0] key_in;
   logic [7:0] key_io_level;
   logic key_io_out_mode;
   logic [1:0] sense_in;
   logic [1:0] sense_in_mode;
   logic timer_zero;
   logic legal;
   logic precond_ok;
   logic is_stop;
   logic wake_now;
   modport decoder (input operand, input key_in, input key_io_level, input key_io_out_mode,
      input sense_in, input sense_in_mode, input timer_zero,
      output legal, output precond_ok, output is_stop, output wake_now);
   modport sequencer (output operand, output key_in, output key_io_level,
      output key_io_out_mode, output sense_in, output sense_in_mode, output timer_zero,
      input legal, input precond_ok, input is_stop, input wake_now);
endinterface

// file: logic/halt_operand_decoder.sv
module halt_operand_decoder
   import standby_pkg::*;
(
   wake_if.decoder w
);
   logic [2:0] mode;
   logic sense_wake;
   logic key_wake;
   assign mode = w.operand[2:0];
   // ***********************************
   // legal patterns and pin preconditions
   // ***********************************
   assign w.is_stop = (mode == op_stop_all_a) || (mode == op_stop_all_b)
      || (mode == op_stop_k0);
   assign w.legal = w.is_stop || (mode == op_halt_timer);
   // key pins must be outputs; all-high or only pin zero high
   always_comb begin
      w.precond_ok = 1'b1;
      if (w.is_stop) begin
         if (!w.key_io_out_mode) begin
            w.precond_ok = 1'b0;
         end else if (mode == op_stop_k0) begin
            w.precond_ok = (w.key_io_level == 8'h01);
         end else begin
            w.precond_ok = (w.key_io_level == 8'hFF);
         end
      end
   end
   // ***********************************
   // wake condition for the chosen mode
   // ***********************************
   assign key_wake = |w.key_in;
   // a sense pin counts only while it is an input
   assign sense_wake = w.operand[op_sense_bit] && |(w.sense_in & w.sense_in_mode);
   assign w.wake_now = w.is_stop ? (key_wake || sense_wake) : w.timer_zero;
endmodule

// file: logic/standby_and_reset_control.sv
// Overview of operation
// - standby only via halt with flag clear
// - wake from standby sets the status flag; a reset in standby clears it
// - halt with flag set: flag follows wake
// - wake already true: skip standby, set flag
// - reset restarts at zero, wake continues
// - operand 0110 stop, key pin zero high
// - bit three adds sense-pin wake source to stop
// - operand x101 halts until timer zero
// - illegal operand or precondition, flag clear, resets system
// - stop first clears a counting timer and output flag
// - stop wake waits, re-stops if wake gone
// - reset pin low halts oscillator, grounds crystal
// - count 246..694 clocks before running
// - power-on clear pulls reset pin low
// - reset loads documented architected values
// - standby reset keeps accumulator and registers
// - rotate-zero and stack faults reset internally
// - high port nibble samples keys, low ones
// - halt keeps clock, stop kills oscillator
module standby_and_reset_control
   import standby_pkg::*;
#(
   parameter int reset_wait_cycles = reset_wait_min,
   parameter int osc_growth_cycles = osc_growth_default,
   parameter int osc_wait_cycles = osc_wait_default
)
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic reset_pin_in,
   input wire logic power_on_clear_in,
   input wire logic halt_exec_in,
   input wire logic [3:0] halt_operand_in,
   input wire logic rotate_left_zero_instruction_in,
   input wire logic acc_zero_in,
   input wire logic stack_fault_in,
   input wire logic [3:0] key_in,
   input wire logic [7:0] key_io_level_in,
   input wire logic [7:0] control_register_one_in,
   input wire logic [1:0] sense_in,
   input wire logic timer_zero_in,
   input wire logic timer_counting_in,
   output logic reset_pin_out,
   output logic reset_pin_oe_n_out,
   output logic cpu_reset_out,
   output logic cpu_run_out,
   output logic osc_enable_out,
   output logic crystal_ground_out,
   output logic timer_clear_out,
   output logic status_flag_out,
   output logic carry_flag_clear_out,
   output logic resume_next_out,
   output logic [9:0] pc_load_value_out,
   output logic stack_pointer_reset_out,
   output logic [9:0] rom_data_pointer_reset_out,
   output logic [9:0] timer_reset_out,
   output logic [7:0] port_register_low_reset_out,
   output logic [7:0] port_register_high_reset_out,
   output logic [7:0] control_register_zero_reset_out,
   output logic [7:0] control_register_one_reset_out,
   output logic keep_registers_out
);
   // elaboration checks: every load must fit the shared wait counter
   if (reset_wait_cycles < reset_wait_min || reset_wait_cycles > reset_wait_max) begin : g_rwait
      $error("reset wait out of range");
   end
   if (osc_growth_cycles < 1 || osc_growth_cycles >= (1 << wait_w)) begin : g_growth
      $error("growth count out of range");
   end
   if (osc_wait_cycles < 1 || osc_wait_cycles >= (1 << wait_w)) begin : g_owait
      $error("wait count out of range");
   end

   localparam logic [wait_w-1:0] reset_wait_load = wait_w'(reset_wait_cycles - 1);
   localparam logic [wait_w-1:0] growth_load = wait_w'(osc_growth_cycles - 1);
   localparam logic [wait_w-1:0] wait_load = wait_w'(osc_wait_cycles - 1);

   // ***********************************
   // reset synchroniser
   // ***********************************
   logic rst_meta_r;
   logic rst_sync_n_r;
   // two flops; the first is read only by the second
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_r <= 1'b0;
         rst_sync_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_n_r <= rst_meta_r;
      end
   end

   // ***********************************
   // operand decode
   // ***********************************
   wake_if w();
   assign w.key_in = key_in;
   assign w.key_io_level = key_io_level_in;
   assign w.key_io_out_mode = control_register_one_in[ctl1_key_io_out_bit];
   assign w.sense_in = sense_in;
   assign w.sense_in_mode = {~control_register_one_in[ctl1_sense1_led_bit],
      control_register_one_in[ctl1_sense0_in_bit]};
   assign w.timer_zero = timer_zero_in;

   halt_operand_decoder u_dec (
      .w(w)
   );

   // ***********************************
   // state and reset sources
   // ***********************************
   seq_state_t state_r;
   seq_state_t state_nxt;
   logic [wait_w-1:0] cnt_r;
   logic [wait_w-1:0] cnt_nxt;
   logic flag_r;
   logic flag_nxt;
   logic stop_mode_r;
   logic resume_r;
   logic keep_r;
   logic internal_reset;
   logic ext_reset;
   logic in_standby;
   logic halt_take;
   logic [3:0] operand_r;

   // pin low or power-on clear holds everything in reset
   assign ext_reset = !reset_pin_in || power_on_clear_in;
   assign halt_take = (state_r == st_run) && halt_exec_in;
   // operand is valid only with the strobe; standby decodes the held copy
   assign w.operand = halt_take ? halt_operand_in : operand_r;

   // keep the taken operand so the wake source cannot drift in standby
   always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         operand_r <= 4'h0;
      end else if (halt_take) begin
         operand_r <= halt_operand_in;
      end
   end
   assign internal_reset = (halt_take && !flag_r && (!w.legal || !w.precond_ok))
      || ((state_r == st_run) && rotate_left_zero_instruction_in && acc_zero_in)
      || ((state_r == st_run) && stack_fault_in);
   assign in_standby = (state_r == st_stop) || (state_r == st_halt)
      || (state_r == st_clear_timer);

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      flag_nxt = flag_r;
      unique case (state_r)
         st_reset: begin
            // the count starts when the pin rises
            cnt_nxt = reset_wait_load;
            if (!ext_reset) begin
               state_nxt = st_wait;
            end
         end
         st_grow: begin
            if (cnt_r == '0) begin
               cnt_nxt = wait_load;
               state_nxt = st_wait;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         st_wait: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 1'b1;
            end else if (stop_mode_r && !w.wake_now) begin
               state_nxt = st_stop;
            end else begin
               if (stop_mode_r) begin
                  flag_nxt = 1'b1;
               end
               state_nxt = st_run;
            end
         end
         st_run: begin
            if (halt_exec_in) begin
               if (flag_r) begin
                  flag_nxt = w.wake_now;
               end else if (w.legal && w.precond_ok) begin
                  if (w.wake_now) begin
                     flag_nxt = 1'b1;
                  end else if (!w.is_stop) begin
                     state_nxt = st_halt;
                  end else if (timer_counting_in) begin
                     state_nxt = st_clear_timer;
                  end else begin
                     state_nxt = st_stop;
                  end
               end
            end
         end
         st_clear_timer: begin
            state_nxt = st_stop;
         end
         st_stop: begin
            if (w.wake_now) begin
               cnt_nxt = growth_load;
               state_nxt = st_grow;
            end
         end
         st_halt: begin
            if (w.wake_now) begin
               flag_nxt = 1'b1;
               state_nxt = st_run;
            end
         end
      endcase
      if (ext_reset || internal_reset) begin
         state_nxt = st_reset;
         flag_nxt = 1'b0;
      end
   end

   // sequencer registers
   always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         state_r <= st_reset;
         cnt_r <= '0;
         flag_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         flag_r <= flag_nxt;
      end
   end

   // remember which standby was taken, for the wait exit
   always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         stop_mode_r <= 1'b0;
      end else if (state_nxt == st_reset) begin
         stop_mode_r <= 1'b0;
      end else if (state_r == st_clear_timer || (state_r == st_run && state_nxt == st_stop)) begin
         stop_mode_r <= 1'b1;
      end else if (state_nxt == st_run) begin
         stop_mode_r <= 1'b0;
      end
   end

   // resume point: zero after reset, next instruction after wake
   always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         resume_r <= 1'b0;
      end else if (state_nxt == st_reset) begin
         resume_r <= 1'b0;
      end else if (in_standby) begin
         resume_r <= 1'b1;
      end else if (state_r == st_run) begin
         resume_r <= 1'b0;
      end
   end

   // a reset caught in standby preserves the register file
   always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         keep_r <= 1'b0;
      end else if (state_r != st_reset && state_nxt == st_reset) begin
         keep_r <= in_standby && ext_reset;
      end
   end

   // high port nibble takes the key levels while in reset
   logic [3:0] key_sample_r;
   always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         key_sample_r <= 4'h0;
      end else if (state_r == st_reset) begin
         key_sample_r <= key_in;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   // pin driven low only while power-on clear asserts
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe_n_out = !power_on_clear_in;
   assign cpu_reset_out = (state_r == st_reset);
   assign cpu_run_out = (state_r == st_run);
   // oscillator dead in reset and stop; halt keeps it alive
   assign osc_enable_out = !(state_r == st_reset || state_r == st_stop);
   assign crystal_ground_out = !osc_enable_out;
   assign timer_clear_out = (state_r == st_clear_timer) || (state_r == st_reset);
   assign status_flag_out = flag_r;
   assign carry_flag_clear_out = (state_r == st_reset);
   assign resume_next_out = resume_r;
   assign pc_load_value_out = pc_reset;
   assign stack_pointer_reset_out = stack_pointer_reset;
   assign rom_data_pointer_reset_out = rom_data_pointer_reset;
   assign timer_reset_out = timer_reset;
   assign port_register_low_reset_out = port_register_low_reset;
   assign port_register_high_reset_out = {key_sample_r, port_register_high_low_nibble};
   assign control_register_zero_reset_out = control_register_zero_reset;
   assign control_register_one_reset_out = control_register_one_reset;
   assign keep_registers_out = keep_r;
endmodule

// file: bench/standby_checker_sva.sv
module standby_checker
   import standby_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic reset_pin_in,
   input wire logic power_on_clear_in,
   input wire logic halt_exec_in,
   input wire logic [3:0] halt_operand_in,
   input wire logic rotate_left_zero_instruction_in,
   input wire logic acc_zero_in,
   input wire logic stack_fault_in,
   input wire logic timer_zero_in,
   input wire logic reset_pin_oe_n_out,
   input wire logic cpu_reset_out,
   input wire logic cpu_run_out,
   input wire logic osc_enable_out,
   input wire logic status_flag_out,
   input wire logic resume_next_out,
   input wire logic [9:0] pc_load_value_out,
   input wire logic [7:0] control_register_one_reset_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // standby and reset properties
   // ****************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   localparam int wait_lo = reset_wait_min;
   localparam int wait_hi = reset_wait_max;
   logic [10:0] wait_cnt_r;
   wire halt_go = cpu_run_out && halt_exec_in;
   wire halt_t = halt_go && (halt_operand_in[2:0] == op_halt_timer);
   // idle cycles between reset and run; saturates so a long halt cannot wrap
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_cnt_r <= '0;
      end else if (cpu_reset_out || cpu_run_out) begin
         wait_cnt_r <= '0;
      end else if (wait_cnt_r != 11'h7ff) begin
         wait_cnt_r <= wait_cnt_r + 11'h001;
      end
   end
   a_reset_osc_off: assert property (cpu_reset_out |-> !osc_enable_out)
      else $error("oscillator running in reset");
   a_pin_forces_reset: assert property ((!reset_pin_in || power_on_clear_in) |=> cpu_reset_out)
      else $error("reset pin low without reset");
   a_poc_pin_drive: assert property (reset_pin_oe_n_out == !power_on_clear_in)
      else $error("pin drive does not follow power-on clear");
   a_reset_values: assert property (cpu_reset_out[*2] |-> !status_flag_out
      && pc_load_value_out == pc_reset && control_register_one_reset_out == 8'h26)
      else $error("reset values wrong");
   a_restart_wait: assert property ($rose(cpu_run_out) && !resume_next_out |->
      wait_cnt_r >= wait_lo && wait_cnt_r <= wait_hi)
      else $error("restart wait out of range");
   a_halt_enters: assert property (halt_t && !status_flag_out && !timer_zero_in |=>
      !cpu_run_out && !cpu_reset_out && osc_enable_out)
      else $error("halt mode not entered");
   a_flag_set_skip: assert property (halt_t && status_flag_out |=>
      cpu_run_out && status_flag_out == $past(timer_zero_in))
      else $error("flag wrong after halt with flag set");
   a_wake_present: assert property (halt_t && !status_flag_out && timer_zero_in |=>
      cpu_run_out && status_flag_out)
      else $error("standby entered with wake present");
   a_timer_wake: assert property (!cpu_run_out && !cpu_reset_out && osc_enable_out
      && $rose(timer_zero_in) |=> cpu_run_out && status_flag_out && resume_next_out)
      else $error("timer wake not taken");
   a_illegal_reset: assert property (halt_go && !status_flag_out && halt_operand_in == 4'h1
      |=> cpu_reset_out)
      else $error("illegal operand without reset");
   a_fault_reset: assert property (cpu_run_out && (stack_fault_in ||
      rotate_left_zero_instruction_in && acc_zero_in) |=> cpu_reset_out)
      else $error("fault without reset");
   c_halt: cover property (halt_t);
   c_wake: cover property ($rose(cpu_run_out) && resume_next_out);
   c_reset: cover property ($rose(cpu_reset_out));
endmodule
bind standby_and_reset_control standby_checker u_chk (.clk_sys_in, .reset_n_in, .reset_pin_in,
   .power_on_clear_in, .halt_exec_in, .halt_operand_in, .rotate_left_zero_instruction_in,
   .acc_zero_in, .stack_fault_in, .timer_zero_in, .reset_pin_oe_n_out, .cpu_reset_out,
   .cpu_run_out, .osc_enable_out, .status_flag_out, .resume_next_out, .pc_load_value_out,
   .control_register_one_reset_out);

// file: bench/key_sense_model.sv
module key_sense_model (
   input wire logic key_press_in,
   input wire logic [1:0] sense_drive_in,
   input wire logic ext_reset_in,
   input wire logic reset_pin_oe_n_in,
   output logic [3:0] key_level_out,
   output logic [1:0] sense_level_out,
   output logic reset_pin_level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // key matrix, sense switches, reset source
   // ****************************************
   // idle keys stay low so a reset release never sees a lone low pin
   assign key_level_out = key_press_in ? 4'h1 : 4'h0; // a press drives key zero only, for as long as the press input stays high
   assign sense_level_out = sense_drive_in;
   // open drain: either side pulls low, the pull-up wins otherwise
   assign reset_pin_level_out = !(ext_reset_in || !reset_pin_oe_n_in);
endmodule

// file: bench/test_standby_and_reset_control.sv
module test_standby_and_reset_control
   import standby_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic clk_sys = 1'b0, reset_n = 1'b0, power_on_clear = 1'b0, halt_exec = 1'b0, rotate_left_zero_instruction = 1'b0;
   logic acc_zero = 1'b0, stack_fault = 1'b0, timer_zero = 1'b0, timer_counting = 1'b0;
   logic key_press = 1'b0, ext_reset = 1'b0, pin_lvl, pin_oe_n, cpu_reset, cpu_run, osc_en;
   logic xtal_gnd, tclr, flag, resume, keep, cy_clr, sp_rst, rst_pin;
   logic [3:0] op = 4'h0, key_lvl;
   logic [1:0] sense_drive = 2'b00, sense_lvl;
   logic [7:0] key_io_level = 8'hff, ctl1 = 8'h26, port_hi, p0, ctl0;
   logic [9:0] pc_val, dp_rst, t_rst;
   logic [3:0] stop_ops [6] = '{4'h0, 4'h3, 4'h6, 4'h8, 4'hb, 4'he};
   int bad_count = 0, total_checks = 0, n;
   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;
   standby_and_reset_control #(.osc_growth_cycles(2), .osc_wait_cycles(3)) dut (
      .clk_sys_in(clk_sys), .reset_n_in(reset_n), .reset_pin_in(pin_lvl),
      .power_on_clear_in(power_on_clear), .halt_exec_in(halt_exec), .halt_operand_in(op),
      .rotate_left_zero_instruction_in(rotate_left_zero_instruction), .acc_zero_in(acc_zero),
      .stack_fault_in(stack_fault), .key_in(key_lvl), .key_io_level_in(key_io_level),
      .control_register_one_in(ctl1), .sense_in(sense_lvl), .timer_zero_in(timer_zero),
      .timer_counting_in(timer_counting), .reset_pin_out(rst_pin), .reset_pin_oe_n_out(pin_oe_n),
      .cpu_reset_out(cpu_reset), .cpu_run_out(cpu_run), .osc_enable_out(osc_en),
      .crystal_ground_out(xtal_gnd), .timer_clear_out(tclr), .status_flag_out(flag),
      .carry_flag_clear_out(cy_clr), .resume_next_out(resume), .pc_load_value_out(pc_val),
      .stack_pointer_reset_out(sp_rst), .rom_data_pointer_reset_out(dp_rst),
      .timer_reset_out(t_rst),
      .port_register_low_reset_out(p0), .port_register_high_reset_out(port_hi),
      .control_register_zero_reset_out(ctl0), .control_register_one_reset_out(),
      .keep_registers_out(keep));
   key_sense_model partner (.key_press_in(key_press), .sense_drive_in(sense_drive),
      .ext_reset_in(ext_reset), .reset_pin_oe_n_in(pin_oe_n), .key_level_out(key_lvl),
      .sense_level_out(sense_lvl), .reset_pin_level_out(pin_lvl));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   // one-cycle halt pulse; returns once the answer is visible
   task automatic halt(input logic [3:0] o);
      @(negedge clk_sys);
      halt_exec = 1'b1;
      op = o;
      @(negedge clk_sys);
      halt_exec = 1'b0;
   endtask
   // bounded wait so a stuck sequencer ends as a mismatch, not a hang
   task automatic wait_run();
      n = 0;
      while (cpu_run !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("run", 1'b1, cpu_run)
   endtask
   // a set flag would skip standby, so spend one halt to clear it
   task automatic clear_flag();
      timer_zero = 1'b0;
      if (flag === 1'b1) halt(4'h5);
   endtask
   initial begin
      tick(12);
      reset_n = 1'b1;
      wait_run();
      `CHK("wait", 1'b1, n >= 246 && n <= 697)
      `CHK("port hi", 8'h0f, port_hi)
      `CHK("port lo", 8'hff, p0)
      `CHK("ctl0", 8'h03, ctl0)
      `CHK("pc", pc_reset, pc_val)
      `CHK("sp dp", 11'h000, {sp_rst, dp_rst})
      `CHK("timer", 10'h000, t_rst)
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         timer_zero = 1'b1;
         halt(i ? 4'hd : 4'h5);
         `CHK("skip", 2'b11, {cpu_run, flag})
         timer_zero = 1'b0;
         halt(4'h5);
         `CHK("flag clr", 1'b0, flag)
         halt(i ? 4'hd : 4'h5);
         `CHK("halted", 2'b01, {cpu_run, osc_en})
         tick(5);
         timer_zero = 1'b1;
         tick(1);
         `CHK("wake", 3'b111, {cpu_run, flag, resume})
      end
      $display("test halt done");
      foreach (stop_ops[i]) begin
         clear_flag();
         key_io_level = (stop_ops[i][2:0] == op_stop_k0) ? 8'h01 : 8'hff;
         ctl1 = stop_ops[i][3] ? 8'h27 : 8'h26;
         timer_counting = (i != 1);
         halt(stop_ops[i]);
         `CHK("tclr", (i != 1), tclr)
         timer_counting = 1'b0;
         tick(2);
         `CHK("stop", 3'b001, {cpu_run, osc_en, xtal_gnd})
         if (i == 0) begin
            key_press = 1'b1;
            tick(1);
            key_press = 1'b0;
            tick(12);
            `CHK("restop", 3'b000, {cpu_run, osc_en, flag})
         end
         if (stop_ops[i][3]) sense_drive = 2'b01;
         else key_press = 1'b1;
         wait_run();
         `CHK("stop wake", 2'b11, {flag, resume})
         key_press = 1'b0;
         sense_drive = 2'b00;
      end
      ctl1 = 8'h26;
      $display("test stop done");
      for (int k = 0; k < 4; k++) begin
         clear_flag();
         key_io_level = (k == 1) ? 8'h00 : 8'hff;
         @(negedge clk_sys);
         rotate_left_zero_instruction = (k == 2);
         acc_zero = (k == 2);
         stack_fault = (k == 3);
         halt_exec = (k < 2);
         op = (k == 0) ? 4'h1 : 4'h0;
         @(negedge clk_sys);
         {rotate_left_zero_instruction, acc_zero, stack_fault, halt_exec} = 4'h0;
         `CHK("int reset", 2'b10, {cpu_reset, keep})
         wait_run();
         `CHK("restart", 1'b0, resume)
      end
      key_io_level = 8'hff;
      $display("test fault done");
      clear_flag();
      halt(4'h5);
      ext_reset = 1'b1;
      tick(3);
      `CHK("pin reset", 4'b1010, {cpu_reset, osc_en, xtal_gnd, flag})
      `CHK("carry clr", 1'b1, cy_clr)
      ext_reset = 1'b0;
      wait_run();
      `CHK("keep", 2'b10, {keep, resume})
      power_on_clear = 1'b1;
      tick(3);
      `CHK("poc", 3'b001, {pin_oe_n, pin_lvl, cpu_reset})
      `CHK("pin drive", 1'b0, rst_pin)
      power_on_clear = 1'b0;
      wait_run();
      `CHK("poc keep", 1'b0, keep)
      $display("test reset pin done");
      end_sim();
   end
   // watchdog well beyond the seven restarts the tests need
   initial begin
      #(25 * 8000);
      bad_count++;
      end_sim();
   end
endmodule
